/* File: inc/pwr_seq_map.svh */
// timing figures and reset levels of the sleep/reset sequencer
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
// ****************************************
// clock and printed times
// ****************************************
`define PS_CLK_HZ   50000000
`define PS_DB_MS    16
`define PS_OVR_S    4
`define PS_TMO_S    4
// ****************************************
// derived cycle counts
// ****************************************
`define PS_DB_CYC   ((`PS_DB_MS * `PS_CLK_HZ) / 1000)
`define PS_OVR_CYC  (`PS_OVR_S * `PS_CLK_HZ)
`define PS_TMO_CYC  (`PS_TMO_S * `PS_CLK_HZ)
// ****************************************
// reset levels
// ****************************************
`define PS_HIGH     1'b1
`define PS_LOW      1'b0
`define PS_CNT_ZERO 32'h0
`define PS_CNT_ONE  32'h1
`endif

/* File: inc/pwr_seq_pkg.sv */
// types shared by the sleep/reset sequencer files
package pwr_seq_pkg;
   // power state, one-hot
   typedef enum logic [3:0] {
      st_s0    = 4'h1,
      st_rst   = 4'h2,
      st_sleep = 4'h4,
      st_deep  = 4'h8
   } pwr_state_t;
   // sleep depth held while in st_sleep
   typedef enum logic [1:0] {
      sx_s3 = 2'h1,
      sx_s4 = 2'h2,
      sx_s5 = 2'h3
   } sleep_type_t;
endpackage

/* File: src/button_debounce.sv */
// level debounce filter for the synchronised power-button level
`include "pwr_seq_map.svh"
module button_debounce #(
   parameter int unsigned DB_CYCLES = `PS_DB_CYC
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic arst_n,
   // filter ports
   input  wire logic raw_lvl,
   output logic      stable_lvl
);
   // ****************************************
   // elaboration check
   // ****************************************
   if (DB_CYCLES < 2) begin : g_chk
      $error("debounce count must be at least 2");
   end

   logic [31:0] cnt_q;      // cycles the raw level differs
   logic [31:0] cnt_d;
   logic        lvl_q;      // filtered level, released = 1
   logic        lvl_d;

   // ****************************************
   // next-state logic
   // ****************************************
   // any bounce back to the stable level restarts the window
   always_comb begin
      cnt_d = `PS_CNT_ZERO;
      lvl_d = lvl_q;
      if (raw_lvl != lvl_q) begin
         if (cnt_q == DB_CYCLES - 1) begin
            lvl_d = raw_lvl;
         end else begin
            cnt_d = cnt_q + `PS_CNT_ONE;
         end
      end
   end

   // registers; button reads released after reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= `PS_CNT_ZERO;
         lvl_q <= `PS_HIGH;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign stable_lvl = lvl_q;

   // a change of the filtered level needs the full quiet window
   db_hold_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (lvl_q != $past(lvl_q)) |-> ($past(cnt_q) == DB_CYCLES - 1))
      else $error("debounced level changed before window");
endmodule

/* File: src/sleep_reset_button_sequencer.sv */
// sleep state, platform reset and power-button sequencer
//
// Functional notes
// - platform reset low in sleep and resets
// - release reset on wake or reset completion
// - button press in S0 raises an interrupt
// - button press while sleeping wakes system
// - long press forces S5 after override time
// - override also acts from S4
// - 16 ms debounce on the button input
// - override S5 continues to deep sleep
// - primary-well reset holds sequencer logic
// - lan sleep control released in S0
// - power-good low forces platform reset
// - 4 s reset-entry timeout: global reset
// - lan control released when always-on released
`include "pwr_seq_map.svh"
module sleep_reset_button_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int unsigned DB_CYCLES  = `PS_DB_CYC,
   parameter int unsigned OVR_CYCLES = `PS_OVR_CYC,
   parameter int unsigned TMO_CYCLES = `PS_TMO_CYC
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // board pins, asynchronous
   input  wire logic       power_button_in_n,
   input  wire logic       core_power_good_in,
   input  wire logic       primary_well_reset_in_n,
   // requests from core logic, same clock
   input  wire logic       sleep_req,
   input  wire logic [1:0] sleep_type_in,
   input  wire logic       reset_req,
   input  wire logic       reset_entry_done,
   input  wire logic       btn_sci_sel,
   input  wire logic       deep_sleep_en,
   input  wire logic       deep_sleep_ok,
   // sleep and reset outputs
   output logic            platform_reset_out_n,
   output logic            lan_sleep_ctl_n,
   output logic            wireless_sleep_ctl_n,
   output logic            always_on_domain_sleep_ctl_n,
   output logic            deep_sleep_state,
   // event pulses
   output logic            system_mgmt_interrupt,
   output logic            control_method_interrupt,
   output logic            global_reset_pulse
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (OVR_CYCLES < 2 || TMO_CYCLES < 2) begin : g_chk
      $error("override and timeout counts must be at least 2");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic pb_m_q, pb_s_q;     // button, first and second stage
   logic pg_m_q, pg_s_q;     // core power good
   logic pw_m_q, pw_s_q;     // primary-well reset release

   // first stages are read only by second stages
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pb_m_q <= `PS_HIGH;
         pb_s_q <= `PS_HIGH;
         pg_m_q <= `PS_LOW;
         pg_s_q <= `PS_LOW;
         pw_m_q <= `PS_LOW;
         pw_s_q <= `PS_LOW;
      end else begin
         pb_m_q <= power_button_in_n;
         pb_s_q <= pb_m_q;
         pg_m_q <= core_power_good_in;
         pg_s_q <= pg_m_q;
         pw_m_q <= primary_well_reset_in_n;
         pw_s_q <= pw_m_q;
      end
   end

   // ****************************************
   // button filter and edges
   // ****************************************
   logic btn_lvl;            // debounced level, released = 1
   logic btn_prev_q;         // level one cycle ago
   logic press;              // debounced press edge
   logic [31:0] ovr_cnt_q;   // cycles held down
   logic [31:0] ovr_cnt_d;
   logic ovr_fire;           // override time reached

   // long bounce filter before anything acts on the button
   button_debounce #(
      .DB_CYCLES (DB_CYCLES)
   ) u_db (
      .mclk       (mclk),
      .arst_n     (arst_n),
      .raw_lvl    (pb_s_q),
      .stable_lvl (btn_lvl)
   );

   assign press = btn_prev_q & ~btn_lvl;

   // override timer; saturates so it fires once per press
   always_comb begin
      ovr_cnt_d = ovr_cnt_q;
      if (btn_lvl) begin
         ovr_cnt_d = `PS_CNT_ZERO;
      end else if (ovr_cnt_q != OVR_CYCLES) begin
         ovr_cnt_d = ovr_cnt_q + `PS_CNT_ONE;
      end
   end

   assign ovr_fire = ~btn_lvl && (ovr_cnt_q == OVR_CYCLES - 1);

   // ****************************************
   // power state machine
   // ****************************************
   pwr_state_t  st_q, st_d;        // current power state
   sleep_type_t typ_q, typ_d;      // depth while sleeping
   logic        ovr_flag_q;        // S5 was reached by override
   logic        ovr_flag_d;
   logic        pcyc_q, pcyc_d;    // power cycle pending
   logic [31:0] tmo_cnt_q;         // reset-entry watchdog
   logic [31:0] tmo_cnt_d;
   logic        glob_d;            // global reset event
   logic        irq_d;             // button sleep request

   // next state; primary-well reset overrides everything
   always_comb begin
      st_d       = st_q;
      typ_d      = typ_q;
      ovr_flag_d = ovr_flag_q;
      pcyc_d     = pcyc_q;
      tmo_cnt_d  = `PS_CNT_ZERO;
      glob_d     = `PS_LOW;
      irq_d      = `PS_LOW;
      if (!pw_s_q) begin
         // wells not stable: park in S5, clear history
         st_d       = st_sleep;
         typ_d      = sx_s5;
         ovr_flag_d = `PS_LOW;
         pcyc_d     = `PS_LOW;
      end else if (ovr_fire && st_q != st_deep) begin
         // every state but st_deep: S0, reset, S3, S4 or S5 alike
         st_d       = st_sleep;
         typ_d      = sx_s5;
         ovr_flag_d = `PS_HIGH;
      end else begin
         case (st_q)
            st_s0: begin
               irq_d = press;
               if (reset_req) begin
                  st_d = st_rst;
               end else if (sleep_req) begin
                  st_d  = st_sleep;
                  typ_d = sleep_type_t'(sleep_type_in);
               end
            end
            st_rst: begin
               tmo_cnt_d = tmo_cnt_q + `PS_CNT_ONE;
               if (reset_entry_done) begin
                  st_d = st_s0;
               end else if (tmo_cnt_q == TMO_CYCLES - 1) begin
                  // stuck entry: power cycle through S5
                  st_d   = st_sleep;
                  typ_d  = sx_s5;
                  pcyc_d = `PS_HIGH;
                  glob_d = `PS_HIGH;
               end
            end
            st_sleep: begin
               if (press) begin
                  st_d       = st_s0;
                  ovr_flag_d = `PS_LOW;
               end else if (pcyc_q) begin
                  // power cycle done, come back up
                  st_d   = st_s0;
                  pcyc_d = `PS_LOW;
               end else if (ovr_flag_q && typ_q == sx_s5 &&
                            deep_sleep_en && deep_sleep_ok) begin
                  st_d       = st_deep;
                  ovr_flag_d = `PS_LOW;
               end
            end
            st_deep: begin
               if (press) begin
                  st_d = st_s0;
               end
            end
            default: begin
               // illegal code: fall to the safe off state
               st_d  = st_sleep;
               typ_d = sx_s5;
            end
         endcase
      end
   end

   // ****************************************
   // output next values
   // ****************************************
   logic plt_n_d, aon_n_d, lan_n_d, wlan_n_d;

   // outputs follow the next state so they change with it
   always_comb begin
      // reset low unless working and core power good
      plt_n_d  = (st_d == st_s0) && pg_s_q;
      aon_n_d  = !(st_d == st_sleep || st_d == st_deep);
      lan_n_d  = (st_d == st_s0) || aon_n_d;
      wlan_n_d = (st_d == st_s0) || aon_n_d;
   end

   // ****************************************
   // state registers
   // ****************************************
   // after reset the system sits off in S5 with reset low
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q                         <= st_sleep;
         typ_q                        <= sx_s5;
         ovr_flag_q                   <= `PS_LOW;
         pcyc_q                       <= `PS_LOW;
         tmo_cnt_q                    <= `PS_CNT_ZERO;
         ovr_cnt_q                    <= `PS_CNT_ZERO;
         btn_prev_q                   <= `PS_HIGH;
         platform_reset_out_n         <= `PS_LOW;
         always_on_domain_sleep_ctl_n <= `PS_LOW;
         lan_sleep_ctl_n              <= `PS_LOW;
         wireless_sleep_ctl_n         <= `PS_LOW;
         deep_sleep_state             <= `PS_LOW;
         system_mgmt_interrupt        <= `PS_LOW;
         control_method_interrupt     <= `PS_LOW;
         global_reset_pulse           <= `PS_LOW;
      end else begin
         st_q                         <= st_d;
         typ_q                        <= typ_d;
         ovr_flag_q                   <= ovr_flag_d;
         pcyc_q                       <= pcyc_d;
         tmo_cnt_q                    <= tmo_cnt_d;
         ovr_cnt_q                    <= ovr_cnt_d;
         btn_prev_q                   <= btn_lvl;
         platform_reset_out_n         <= plt_n_d;
         always_on_domain_sleep_ctl_n <= aon_n_d;
         lan_sleep_ctl_n              <= lan_n_d;
         wireless_sleep_ctl_n         <= wlan_n_d;
         deep_sleep_state             <= (st_d == st_deep);
         system_mgmt_interrupt        <= irq_d & ~btn_sci_sel;
         control_method_interrupt     <= irq_d & btn_sci_sel;
         global_reset_pulse           <= glob_d;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   // a press seen in S0 with stable wells
   sequence s0_press_s;
      st_q == st_s0 && press && pw_s_q && !ovr_fire;
   endsequence

   // the reset entry ends on its handshake
   sequence entry_done_s;
      st_q == st_rst && reset_entry_done && pw_s_q && !ovr_fire;
   endsequence

   sleep_holds_reset_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (st_q == st_sleep || st_q == st_rst) |-> !platform_reset_out_n)
      else $error("platform reset released while not working");

   reset_release_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      entry_done_s ##0 pg_s_q |=> platform_reset_out_n && st_q == st_s0)
      else $error("platform reset not released after entry");

   power_good_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      !pg_s_q |=> !platform_reset_out_n)
      else $error("platform reset high without power good");

   button_irq_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      s0_press_s |=> (system_mgmt_interrupt != control_method_interrupt)
      ##1 !(system_mgmt_interrupt || control_method_interrupt))
      else $error("button interrupt missing or held");

   button_wake_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (st_q == st_sleep || st_q == st_deep) && press && pw_s_q
      |=> st_q == st_s0 && platform_reset_out_n == $past(pg_s_q))
      else $error("button press did not wake");

   override_s5_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ovr_fire && pw_s_q && st_q != st_deep
      |=> st_q == st_sleep && typ_q == sx_s5 && !platform_reset_out_n)
      else $error("override did not force S5");

   override_deep_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ovr_fire && pw_s_q && st_q != st_deep ##1
      (deep_sleep_en && deep_sleep_ok && !press && !pcyc_q && pw_s_q)
      |=> deep_sleep_state && st_q == st_deep)
      else $error("override S5 did not go to deep sleep");

   well_reset_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      !pw_s_q [*2] |-> st_q == st_sleep && !platform_reset_out_n)
      else $error("logic not held during primary-well reset");

   lan_released_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      (st_q == st_s0 || always_on_domain_sleep_ctl_n)
      |-> lan_sleep_ctl_n && wireless_sleep_ctl_n)
      else $error("lan sleep control asserted while powered");

   entry_timeout_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      st_q == st_rst && tmo_cnt_q == TMO_CYCLES - 1 && !reset_entry_done
      && pw_s_q && !ovr_fire |=> global_reset_pulse ##1 st_q == st_s0)
      else $error("reset entry timeout not taken");

   override_clear_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      btn_lvl |=> ovr_cnt_q == `PS_CNT_ZERO && !ovr_fire)
      else $error("override timer not cleared on release");
endmodule

/* File: test/board_power_model.sv */
// board power logic, button and controller model facing the sequencer
module board_power_model #(
   parameter int unsigned HOLD_CYC = 60
) (
   // clock
   input  wire logic mclk,
   // reset request seen by the controller
   input  wire logic reset_req,
   // board pins and controller answer
   output logic      power_button_in_n,
   output logic      core_power_good_in,
   output logic      primary_well_reset_in_n,
   output logic      reset_entry_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned entry_dly; // cycles to answer a reset, 0 stays silent
   int unsigned wait_cnt;  // countdown toward the answer
   // power-up: wells held in reset well after they become valid
   initial begin
      power_button_in_n       = 1'b1; // pull-up keeps released level
      core_power_good_in      = 1'b1;
      primary_well_reset_in_n = 1'b0;
      reset_entry_done        = 1'b0;
      entry_dly               = 0;
      wait_cnt                = 0;
      repeat (HOLD_CYC) @(posedge mclk);
      primary_well_reset_in_n <= 1'b1;
   end
   // controller finishes reset entry after a set delay, never early
   always @(posedge mclk) begin
      reset_entry_done <= 1'b0;
      if (reset_req === 1'b1 && entry_dly != 0) begin
         wait_cnt <= entry_dly;
      end else if (wait_cnt == 1) begin
         reset_entry_done <= 1'b1;
         wait_cnt         <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
   // hold the button down for a number of cycles, then let go
   task automatic press(input int unsigned cycles);
      @(posedge mclk);
      power_button_in_n <= 1'b0;
      repeat (cycles) @(posedge mclk);
      power_button_in_n <= 1'b1;
   endtask
   // move the core power-good level
   task automatic set_power_good(input logic v);
      @(posedge mclk);
      core_power_good_in <= v;
   endtask
endmodule

/* File: test/tb_sleep_reset_button_sequencer.sv */
// self-checking bench for the sleep, reset and button sequencer
module tb_sleep_reset_button_sequencer
   import pwr_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************
   // signals
   // ***************************************
   logic       mclk, arst_n;              // clock and async reset
   logic       sleep_req, reset_req;      // core requests
   logic [1:0] sleep_type_in;             // requested sleep depth
   logic       btn_sci_sel;               // interrupt kind for a press
   logic       deep_sleep_en, deep_sleep_ok; // deep sleep policy
   wire        power_button_in_n, core_power_good_in;
   wire        primary_well_reset_in_n, reset_entry_done;
   wire        platform_reset_out_n, lan_sleep_ctl_n;
   wire        wireless_sleep_ctl_n, always_on_domain_sleep_ctl_n;
   wire        deep_sleep_state, system_mgmt_interrupt;
   wire        control_method_interrupt, global_reset_pulse;
   wire  [7:0] lv;                        // reset and sleep levels
   wire  [2:0] pulses;                    // event pulses
   logic [2:0] exp_q[$];                  // expected events, oldest first
   logic [7:0] rnd;                       // lfsr state
   int         fails, num_checks;
   // zero-extended so every compare runs at the checker's width
   assign lv = {4'h0, platform_reset_out_n, always_on_domain_sleep_ctl_n,
                lan_sleep_ctl_n, wireless_sleep_ctl_n};
   assign pulses = {system_mgmt_interrupt, control_method_interrupt,
                    global_reset_pulse};
   // ***************************************
   // clock, design and board
   // ***************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // short counts keep the run brief; expectations follow them
   sleep_reset_button_sequencer #(
      .DB_CYCLES (4),
      .OVR_CYCLES(40),
      .TMO_CYCLES(30)
   ) uut (
      .mclk                        (mclk),
      .arst_n                      (arst_n),
      .power_button_in_n           (power_button_in_n),
      .core_power_good_in          (core_power_good_in),
      .primary_well_reset_in_n     (primary_well_reset_in_n),
      .sleep_req                   (sleep_req),
      .sleep_type_in               (sleep_type_in),
      .reset_req                   (reset_req),
      .reset_entry_done            (reset_entry_done),
      .btn_sci_sel                 (btn_sci_sel),
      .deep_sleep_en               (deep_sleep_en),
      .deep_sleep_ok               (deep_sleep_ok),
      .platform_reset_out_n        (platform_reset_out_n),
      .lan_sleep_ctl_n             (lan_sleep_ctl_n),
      .wireless_sleep_ctl_n        (wireless_sleep_ctl_n),
      .always_on_domain_sleep_ctl_n(always_on_domain_sleep_ctl_n),
      .deep_sleep_state            (deep_sleep_state),
      .system_mgmt_interrupt       (system_mgmt_interrupt),
      .control_method_interrupt    (control_method_interrupt),
      .global_reset_pulse          (global_reset_pulse)
   );
   board_power_model #(.HOLD_CYC(60)) board (
      .mclk                   (mclk),
      .reset_req              (reset_req),
      .power_button_in_n      (power_button_in_n),
      .core_power_good_in     (core_power_good_in),
      .primary_well_reset_in_n(primary_well_reset_in_n),
      .reset_entry_done       (reset_entry_done)
   );
   // ***************************************
   // helpers
   // ***************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // let n edges pass, then sample once their updates have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one-cycle request; outputs sampled after the taking edge
   task automatic request(input logic rst, input logic [1:0] t);
      @(posedge mclk);
      reset_req     <= rst;
      sleep_req     <= ~rst;
      sleep_type_in <= t;
      @(posedge mclk);
      reset_req <= 1'b0;
      sleep_req <= 1'b0;
      #1;
   endtask
   // short press and enough time for the release to settle
   task automatic tap;
      board.press(12);
      wait_cyc(12);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ***************************************
   // event monitor and watchdog
   // ***************************************
   // any pulse must match the oldest note; unexpected ones fail
   always @(posedge mclk) begin
      if (arst_n === 1'b1 && pulses !== 3'h0) begin
         if (exp_q.size() == 0) begin
            check("event", 8'(pulses), 8'h0);
         end else begin
            check("event", 8'(pulses), 8'(exp_q.pop_front()));
         end
      end
   end
   // the sequence needs well under 2000 cycles
   initial begin
      repeat (8000) @(posedge mclk);
      fails++;
      complete_run();
   end
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      arst_n        = 1'b0;
      sleep_req     = 1'b0;
      reset_req     = 1'b0;
      sleep_type_in = sx_s3;
      btn_sci_sel   = 1'b0;
      deep_sleep_en = 1'b0;
      deep_sleep_ok = 1'b0;
      fails         = 0;
      num_checks    = 0;
      rnd           = 8'h22;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      wait_cyc(2);
      check("after reset", lv, 8'h0);
      // a press while the wells are still held must do nothing
      tap();
      check("held", lv, 8'h0);
      for (int i = 0; i < 100 && primary_well_reset_in_n !== 1'b1; i++)
         @(posedge mclk);
      wait_cyc(4);
      // bounce shorter than the filter
      board.press(3);
      wait_cyc(12);
      check("bounce", lv, 8'h0);
      tap();
      check("wake", lv, 8'hF);
      check("deep", 8'(deep_sleep_state), 8'h0);
      // presses in S0 of random length, both interrupt kinds
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         @(posedge mclk);
         btn_sci_sel <= i[0];
         // deep sleep still disabled, so its permit may wander freely
         deep_sleep_ok <= rnd[0];
         exp_q.push_back(i[0] ? 3'b010 : 3'b100);
         board.press(8 + int'(rnd[7:4]));
         wait_cyc(12);
      end
      // two long presses, each shorter than the override time
      exp_q.push_back(3'b010);
      exp_q.push_back(3'b010);
      board.press(30);
      wait_cyc(15);
      board.press(30);
      wait_cyc(12);
      check("no override", lv, 8'hF);
      // every sleep depth, then wake by button
      for (int t = 1; t < 4; t++) begin
         request(1'b0, t[1:0]);
         check("sleep", lv, 8'h0);
         // early wake: wireless control needs no minimum low time
         wait_cyc(3);
         tap();
         check("sleep wake", lv, 8'hF);
      end
      // long press from S4: wakes to S0, then override to S5, deep sleep enabled but conditions unmet
      @(posedge mclk);
      deep_sleep_en <= 1'b1;
      deep_sleep_ok <= 1'b0;
      request(1'b0, sx_s4);
      board.press(60);
      wait_cyc(12);
      check("s4 override", lv, 8'h0);
      check("no deep", 8'(deep_sleep_state), 8'h0);
      tap();
      // override from S0 continuing into deep sleep
      @(posedge mclk);
      deep_sleep_en <= 1'b1;
      deep_sleep_ok <= 1'b1;
      btn_sci_sel   <= 1'b0;
      exp_q.push_back(3'b100);
      board.press(60);
      wait_cyc(12);
      check("override", lv, 8'h0);
      check("deep entry", 8'(deep_sleep_state), 8'h1);
      tap();
      check("deep wake", {deep_sleep_state, lv[6:0]}, 8'h0F);
      @(posedge mclk);
      deep_sleep_en <= 1'b0;
      // reset answered after a random delay within the timeout
      rnd = lfsr(rnd);
      board.entry_dly = 1 + int'(rnd[3:0]);
      request(1'b1, sx_s3);
      check("reset entry", lv, 8'h7);
      wait_cyc(20);
      check("reset done", lv, 8'hF);
      // reset never answered: global reset with power cycle
      board.entry_dly = 0;
      exp_q.push_back(3'b001);
      request(1'b1, sx_s3);
      wait_cyc(40);
      check("timeout back", lv, 8'hF);
      // core power good dropping forces the platform reset
      board.set_power_good(1'b0);
      wait_cyc(5);
      // any low counts here; nothing waits for a minimum reset width
      check("power good low", lv, 8'h7);
      board.set_power_good(1'b1);
      wait_cyc(5);
      check("power good back", lv, 8'hF);
      wait_cyc(4);
      check("pending", 8'(exp_q.size()), 8'h0);
      complete_run();
   end
endmodule
